// ==== rtl/dbl_pkg.sv ====
// Shared constants, types and helpers for the burst and latency link
// Overview of operation
// R1 - Fixed eight code: eight beats, A12 ignored
// R2 - On-the-fly code: A12 high eight, low four
// R3 - Fixed chop code: four beats for every command
// R4 - Parity on: read latency adds parity latency
// R5 - Latency mode leaves termination timing unchanged
// R6 - Write timing holds only with loop locked
// R7 - Untrained host widens window by twice skew
// R8 - Command sampled programmed clocks after select
package dbl_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DBL_AW = 16;
  localparam int DBL_DW = 8;
  localparam int DBL_CW = 6;
  localparam int DBL_WDW = 64;

  // ----------------------------------------
  // Mode word fields
  // ----------------------------------------
  localparam int DBL_BL_LSB = 0;
  localparam int DBL_CL_LSB = 2;
  localparam int DBL_CWL_LSB = 6;
  localparam int DBL_PAR_BIT = 10;
  localparam int DBL_AL_BIT = 11;
  localparam int DBL_OTF_BIT = 12;
  localparam int DBL_CAL_LSB = 13;
  localparam logic [1:0] DBL_BL_FIX8 = 2'h0;
  localparam logic [1:0] DBL_BL_OTF = 2'h1;
  localparam logic [1:0] DBL_BL_FIX4 = 2'h2;
  localparam logic [15:0] DBL_MR_RESET = 16'h026c;

  // ----------------------------------------
  // Counts and timing
  // ----------------------------------------
  localparam logic [3:0] DBL_BEATS8 = 4'h8;
  localparam logic [3:0] DBL_BEATS4 = 4'h4;
  localparam logic [5:0] DBL_PL = 6'h04;
  localparam int DBL_CLK_NS = 25;
  localparam int DBL_CK_NS = 200;
  localparam int DBL_CK_HALF = DBL_CK_NS / (2 * DBL_CLK_NS);

  typedef enum logic [1:0] {DBL_CMD_NOP, DBL_CMD_MRS, DBL_CMD_RD, DBL_CMD_WR} dbl_cmd_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] dbl_beats(input logic [15:0] mr, input logic a12);
    unique case (mr[DBL_BL_LSB +: 2])
      DBL_BL_OTF: dbl_beats = a12 ? DBL_BEATS8 : DBL_BEATS4; // [R2]
      DBL_BL_FIX4: dbl_beats = DBL_BEATS4; // [R3]
      default: dbl_beats = DBL_BEATS8; // [R1]
    endcase
  endfunction : dbl_beats

  function automatic logic [5:0] dbl_al(input logic [15:0] mr);
    logic [5:0] cl;
    cl = {2'h0, mr[DBL_CL_LSB +: 4]};
    dbl_al = mr[DBL_AL_BIT] ? cl - 6'h01 : 6'h00;
  endfunction : dbl_al

  function automatic logic [5:0] dbl_rd_lat(input logic [15:0] mr);
    logic [5:0] pl;
    pl = mr[DBL_PAR_BIT] ? DBL_PL : 6'h00;
    dbl_rd_lat = {2'h0, mr[DBL_CL_LSB +: 4]} + dbl_al(mr) + pl; // [R4]
  endfunction : dbl_rd_lat

  function automatic logic [5:0] dbl_wr_lat(input logic [15:0] mr);
    logic [5:0] pl;
    pl = mr[DBL_PAR_BIT] ? DBL_PL : 6'h00;
    dbl_wr_lat = {2'h0, mr[DBL_CWL_LSB +: 4]} + dbl_al(mr) + pl;
  endfunction : dbl_wr_lat

endpackage : dbl_pkg

// ==== rtl/dbl_if.sv ====
// Link between memory controller end and memory device end
`timescale 1ns/100ps
interface dbl_if;
  import dbl_pkg::*;
  logic ck;
  logic cs_n;
  dbl_cmd_t cmd;
  logic [DBL_AW-1:0] addr;
  logic odt;
  logic [DBL_DW-1:0] dq_h;
  logic dq_h_oe;
  logic [DBL_DW-1:0] dq_d;
  logic dq_d_oe;
  logic [DBL_DW-1:0] dq;
  logic dll_ok;

  // Shared data wire level
  assign dq = dq_h_oe ? dq_h : (dq_d_oe ? dq_d : 8'h00);

  modport dev (input ck, cs_n, cmd, addr, odt, dq, output dq_d, dq_d_oe, dll_ok);
  modport host (output ck, cs_n, cmd, addr, odt, dq_h, dq_h_oe, input dq, dll_ok);
endinterface : dbl_if

// ==== rtl/dbl_dev.sv ====
// Memory device end: mode word, burst length, latency, data beats
`timescale 1ns/100ps
module dbl_dev
  import dbl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  dbl_if.dev link,
  input wire logic dll_locked,
  output logic [15:0] mode_word,
  output logic [5:0] rd_lat,
  output logic term_on,
  output logic wr_beat,
  output logic wr_drop
);

  typedef enum logic [1:0] {DS_IDLE, DS_CAL, DS_LAT, DS_BURST} dbl_dst_t;
  localparam int SW = 4 + DBL_AW + 1 + DBL_DW;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic ck_prev;
  logic ck_s;
  logic cs_s;
  logic [1:0] cmd_b;
  logic [DBL_AW-1:0] addr_s;
  logic odt_s;
  logic [DBL_DW-1:0] dq_s;
  logic rise;
  logic fall;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
      ck_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {link.ck, link.cs_n, link.cmd, link.addr, link.odt, link.dq};
      sync2 <= sync1;
      ck_prev <= ck_s;
    end
  end

  assign {ck_s, cs_s, cmd_b, addr_s, odt_s, dq_s} = sync2;
  assign rise = ck_s & ~ck_prev;
  assign fall = ~ck_s & ck_prev;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  dbl_dst_t state;
  logic [5:0] cnt;
  logic [3:0] beat;
  logic [3:0] nbeat;
  logic [DBL_CW-1:0] col;
  logic is_wr;
  logic take;
  logic [2:0] cal;
  logic [DBL_CW-1:0] idx;
  logic [DBL_CW-1:0] idx_nx;
  logic last;

  assign cal = mode_word[DBL_CAL_LSB +: 3];
  assign take = rise && ((state == DS_IDLE && !cs_s && cal == 3'h0) ||
                         (state == DS_CAL && cnt == 6'h01)); // [R8]
  assign idx = col + {2'h0, beat};
  assign idx_nx = idx + 6'h01;
  assign last = (beat == nbeat - 4'h1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= DS_IDLE;
      cnt <= 6'h00;
      beat <= 4'h0;
      nbeat <= 4'h0;
      col <= '0;
      is_wr <= 1'b0;
      mode_word <= DBL_MR_RESET;
    end
    else if (take)
    begin
      beat <= 4'h0;
      unique case (dbl_cmd_t'(cmd_b))
        DBL_CMD_NOP:
          state <= DS_IDLE;
        DBL_CMD_MRS:
        begin
          mode_word <= addr_s;
          state <= DS_IDLE;
        end
        DBL_CMD_RD, DBL_CMD_WR:
        begin
          is_wr <= (dbl_cmd_t'(cmd_b) == DBL_CMD_WR);
          cnt <= (dbl_cmd_t'(cmd_b) == DBL_CMD_WR) ? dbl_wr_lat(mode_word) : dbl_rd_lat(mode_word); // [R4]
          nbeat <= dbl_beats(mode_word, addr_s[DBL_OTF_BIT]); // [R1] [R2] [R3]
          col <= addr_s[DBL_CW-1:0];
          state <= DS_LAT;
        end
      endcase
    end
    else if (rise)
    begin
      unique case (state)
        DS_IDLE:
        begin
          if (!cs_s)
          begin
            cnt <= {3'h0, cal}; // [R8]
            state <= DS_CAL;
          end
        end
        DS_CAL, DS_LAT:
          cnt <= cnt - 6'h01;
        DS_BURST:
          ;
      endcase
    end
    else if (fall)
    begin
      if (state == DS_LAT && cnt == 6'h01)
        state <= DS_BURST;
      else if (state == DS_BURST)
      begin
        if (last)
          state <= DS_IDLE;
        else
          beat <= beat + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Data array and beats
  // ----------------------------------------
  logic [DBL_DW-1:0] mem [2**DBL_CW];
  logic wr_ok;

  assign wr_ok = rise && state == DS_BURST && is_wr;

  always_ff @(posedge clk)
  begin
    if (wr_ok && link.dll_ok)
      mem[idx] <= dq_s; // [R6]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.dq_d <= 8'h00;
      link.dq_d_oe <= 1'b0;
    end
    else if (fall && !is_wr)
    begin
      if (state == DS_LAT && cnt == 6'h01)
      begin
        link.dq_d <= mem[idx];
        link.dq_d_oe <= 1'b1;
      end
      else if (state == DS_BURST)
      begin
        link.dq_d <= mem[idx_nx];
        link.dq_d_oe <= !last;
      end
    end
  end

  // ----------------------------------------
  // Status and termination
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.dll_ok <= 1'b0;
      rd_lat <= 6'h00;
      term_on <= 1'b0;
      wr_beat <= 1'b0;
      wr_drop <= 1'b0;
    end
    else
    begin
      link.dll_ok <= dll_locked; // [R6]
      rd_lat <= dbl_rd_lat(mode_word);
      wr_beat <= wr_ok && link.dll_ok;
      wr_drop <= wr_ok && !link.dll_ok; // [R6]
      if (rise)
        term_on <= odt_s; // [R5]
    end
  end

endmodule : dbl_dev

// ==== rtl/dbl_host.sv ====
// Memory controller end: clock, command issue, latency, data beats
`timescale 1ns/100ps
module dbl_host
  import dbl_pkg::*;
#(
  parameter int CK_HALF = DBL_CK_HALF,
  parameter int SKEW_CYC = 1
)
(
  input wire logic clk,
  input wire logic rst,
  dbl_if.host link,
  input wire logic trained,
  input wire logic req_valid,
  input wire dbl_cmd_t req_cmd,
  input wire logic [DBL_AW-1:0] req_addr,
  input wire logic [DBL_WDW-1:0] req_wdata,
  output logic req_ready,
  output logic req_err,
  output logic rd_valid,
  output logic [DBL_DW-1:0] rd_data,
  output logic done
);

  typedef enum logic [2:0] {HS_IDLE, HS_ISSUE, HS_CAL, HS_LAT, HS_BURST, HS_HOLD} dbl_hst_t;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (CK_HALF < 4 || CK_HALF > 255)
  begin : g_bad_half
    $error("CK_HALF must lie in 4..255");
  end
  if (SKEW_CYC < 1 || 2 * SKEW_CYC > 255)
  begin : g_bad_skew
    $error("SKEW_CYC must lie in 1..127");
  end

  localparam logic [7:0] HALF_M1 = 8'(CK_HALF - 1);
  localparam logic [7:0] HOLD_CYC = 8'(2 * SKEW_CYC);

  // ----------------------------------------
  // Link clock divider
  // ----------------------------------------
  logic [7:0] div;
  logic tick;
  logic rise_en;
  logic fall_en;

  assign tick = (div == HALF_M1);
  assign rise_en = tick & ~link.ck;
  assign fall_en = tick & link.ck;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div <= 8'h00;
      link.ck <= 1'b0;
    end
    else if (tick)
    begin
      div <= 8'h00;
      link.ck <= ~link.ck;
    end
    else
    begin
      div <= div + 8'h01;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [DBL_DW-1:0] dq1;
  logic [DBL_DW-1:0] dq2;
  logic dll1;
  logic dll2;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dq1 <= 8'h00;
      dq2 <= 8'h00;
      dll1 <= 1'b0;
      dll2 <= 1'b0;
    end
    else
    begin
      dq1 <= link.dq;
      dq2 <= dq1;
      dll1 <= link.dll_ok;
      dll2 <= dll1;
    end
  end

  // ----------------------------------------
  // Request sequencer
  // ----------------------------------------
  dbl_hst_t state;
  dbl_cmd_t cur_cmd;
  logic [DBL_AW-1:0] cur_addr;
  logic [DBL_WDW-1:0] wdata;
  logic [15:0] shadow;
  logic [7:0] cnt;
  logic [3:0] beat;
  logic [3:0] nbeat;
  logic [5:0] lat_sel;
  logic is_wr;
  logic last;
  logic [2:0] cal;

  assign cal = shadow[DBL_CAL_LSB +: 3];
  assign is_wr = (cur_cmd == DBL_CMD_WR);
  assign last = (beat == nbeat - 4'h1);
  assign lat_sel = (cur_cmd == DBL_CMD_RD) ? dbl_rd_lat(shadow) : dbl_wr_lat(shadow); // [R4]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= HS_IDLE;
      cur_cmd <= DBL_CMD_NOP;
      cur_addr <= '0;
      wdata <= '0;
      shadow <= DBL_MR_RESET;
      cnt <= 8'h00;
      beat <= 4'h0;
      nbeat <= 4'h0;
      req_ready <= 1'b1;
      req_err <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      link.cs_n <= 1'b1;
      link.cmd <= DBL_CMD_NOP;
      link.addr <= '0;
      link.odt <= 1'b0;
      link.dq_h <= 8'h00;
      link.dq_h_oe <= 1'b0;
    end
    else
    begin
      req_err <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      unique case (state)
        HS_IDLE:
        begin
          if (req_valid)
          begin
            if (req_cmd == DBL_CMD_NOP || (req_cmd == DBL_CMD_WR && !dll2))
              req_err <= 1'b1; // [R6]
            else
            begin
              cur_cmd <= req_cmd;
              cur_addr <= req_addr;
              wdata <= req_wdata;
              req_ready <= 1'b0;
              state <= HS_ISSUE;
            end
          end
        end
        HS_ISSUE:
        begin
          if (fall_en)
          begin
            link.cs_n <= 1'b0;
            nbeat <= dbl_beats(shadow, cur_addr[DBL_OTF_BIT]); // [R1] [R2] [R3]
            cnt <= {5'h00, cal};
            state <= HS_CAL;
            if (cal == 3'h0)
            begin
              link.cmd <= cur_cmd;
              link.addr <= cur_addr;
              link.odt <= is_wr; // [R5]
              cnt <= {2'h0, lat_sel} + 8'h01;
              state <= HS_LAT;
              if (cur_cmd == DBL_CMD_MRS)
                shadow <= cur_addr;
            end
          end
        end
        HS_CAL:
        begin
          if (fall_en)
          begin
            link.cs_n <= 1'b1;
            if (cnt == 8'h01)
            begin
              link.cmd <= cur_cmd; // [R8]
              link.addr <= cur_addr;
              link.odt <= is_wr; // [R5]
              cnt <= {2'h0, lat_sel} + 8'h01;
              state <= HS_LAT;
              if (cur_cmd == DBL_CMD_MRS)
                shadow <= cur_addr;
            end
            else
              cnt <= cnt - 8'h01;
          end
        end
        HS_LAT:
        begin
          if (rise_en)
            cnt <= cnt - 8'h01;
          else if (fall_en)
          begin
            link.cs_n <= 1'b1;
            link.cmd <= DBL_CMD_NOP;
            beat <= 4'h0;
            if (cur_cmd == DBL_CMD_MRS)
            begin
              done <= 1'b1;
              req_ready <= 1'b1;
              state <= HS_IDLE;
            end
            else if (cnt == 8'h01)
            begin
              state <= HS_BURST;
              if (is_wr)
              begin
                link.dq_h <= wdata[7:0];
                link.dq_h_oe <= 1'b1;
              end
            end
          end
        end
        HS_BURST:
        begin
          if (fall_en)
          begin
            if (!is_wr)
            begin
              rd_data <= dq2;
              rd_valid <= 1'b1;
            end
            if (last)
            begin
              link.odt <= 1'b0;
              if (is_wr && !trained)
              begin
                cnt <= HOLD_CYC; // [R7]
                state <= HS_HOLD;
              end
              else
              begin
                link.dq_h_oe <= 1'b0;
                done <= 1'b1;
                req_ready <= 1'b1;
                state <= HS_IDLE;
              end
            end
            else
            begin
              beat <= beat + 4'h1;
              wdata <= {8'h00, wdata[DBL_WDW-1:8]};
              link.dq_h <= wdata[15:8];
            end
          end
        end
        HS_HOLD:
        begin
          if (cnt == 8'h01)
          begin
            link.dq_h_oe <= 1'b0; // [R7]
            done <= 1'b1;
            req_ready <= 1'b1;
            state <= HS_IDLE;
          end
          else
            cnt <= cnt - 8'h01;
        end
        default:
          state <= HS_IDLE;
      endcase
    end
  end

endmodule : dbl_host

// ==== tb/dbl_link_assertions.sv ====
// Link checker for the burst and latency link
`timescale 1ns/100ps
module dbl_link_chk
  import dbl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire dbl_cmd_t cmd,
  input wire logic [DBL_AW-1:0] addr,
  input wire logic odt,
  input wire logic dq_h_oe,
  input wire logic dq_d_oe,
  input wire logic dll_ok
);
  // ----------------
  // Expected figures
  // ----------------
  logic [15:0] mode_q;
  logic a12_q;
  logic cs_q;
  logic [9:0] lat;
  logic [9:0] rcnt;
  logic [9:0] wcnt;
  int cl;
  int al;
  int nb;
  int rl;
  int wl;
  always_comb
  begin
    cl = int'(mode_q[5:2]);
    al = mode_q[11] ? cl - 1 : 0;
    rl = int'(mode_q[15:13]) + cl + al + (mode_q[10] ? 4 : 0);
    wl = rl - cl + int'(mode_q[9:6]);
    nb = (mode_q[1:0] == 2'h2 || (mode_q[1:0] == 2'h1 && !a12_q)) ? 4 : 8;
  end
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      mode_q <= DBL_MR_RESET;
      a12_q <= 1'b0;
    end
    else if (cmd == DBL_CMD_MRS)
      mode_q <= addr;
    else if (cmd != DBL_CMD_NOP)
      a12_q <= addr[12];
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cs_q <= 1'b1;
      lat <= 10'h000;
      rcnt <= 10'h000;
      wcnt <= 10'h000;
    end
    else
    begin
      cs_q <= cs_n;
      lat <= (cs_q && !cs_n) ? 10'h001 : ((lat == 10'h3ff) ? lat : lat + 10'h001);
      rcnt <= dq_d_oe ? rcnt + 10'h001 : 10'h000;
      wcnt <= dq_h_oe ? wcnt + 10'h001 : 10'h000;
    end
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  cs_pulse_a: assert property ($fell(cs_n) |-> !cs_n [*8] ##1 cs_n)
    else $error("select low time wrong");
  rd_lat_a: assert property ($rose(dq_d_oe) |-> (int'(lat) + 2) / 8 == rl)
    else $error("read latency wrong");
  wr_lat_a: assert property ($rose(dq_h_oe) |-> (int'(lat) + 2) / 8 == wl)
    else $error("write latency wrong");
  rd_beats_a: assert property ($fell(dq_d_oe) |-> (int'(rcnt) + 2) / 8 == nb)
    else $error("read beat count wrong");
  wr_beats_a: assert property ($fell(dq_h_oe) |-> (int'(wcnt) + 2) / 8 == nb)
    else $error("write beat count wrong");
  odt_start_a: assert property ($rose(odt) |-> cmd == DBL_CMD_WR || !cs_n)
    else $error("termination start wrong");
  odt_cover_a: assert property ($rose(dq_h_oe) |-> odt)
    else $error("termination off during write");
  dll_gate_a: assert property ($rose(dq_h_oe) |-> dll_ok)
    else $error("write data without lock");
  no_clash_a: assert property (!(dq_h_oe && dq_d_oe))
    else $error("both ends drive data");
endmodule : dbl_link_chk

// ==== tb/dram_burst_latency_config_test.sv ====
// Self-checking bench for both link ends
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module dram_burst_latency_config_test;
  import dbl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dll_locked = 1'b0;
  logic trained = 1'b1;
  logic req_valid = 1'b0;
  dbl_cmd_t req_cmd = DBL_CMD_NOP;
  logic [DBL_AW-1:0] req_addr = 16'h0000;
  logic [DBL_WDW-1:0] req_wdata = 64'h0;
  logic req_ready, req_err, rd_valid, done, wr_beat, wr_drop;
  logic [DBL_DW-1:0] rd_data;
  logic [15:0] mode_word;
  logic [5:0] rd_lat;
  logic term_on;
  int err_total = 0;
  int checks = 0;
  int mode = 16'h026c;
  int mem [64];
  int n_beat = 0;
  int n_drop = 0;
  int n_term = 0;
  int n_oe = 0;
  bit drop_dll = 0;
  // ----------------
  // Both ends
  // ----------------
  dbl_if dbl_if_inst ();
  dbl_dev dbl_dev_inst (.clk(clk), .rst(rst), .link(dbl_if_inst), .dll_locked(dll_locked),
    .mode_word(mode_word), .rd_lat(rd_lat), .term_on(term_on), .wr_beat(wr_beat), .wr_drop(wr_drop));
  dbl_host dbl_host_inst (.clk(clk), .rst(rst), .link(dbl_if_inst), .trained(trained), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .req_err(req_err),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done));
  dbl_link_chk dbl_link_chk_inst (.clk(clk), .rst(rst), .cs_n(dbl_if_inst.cs_n), .cmd(dbl_if_inst.cmd),
    .addr(dbl_if_inst.addr), .odt(dbl_if_inst.odt), .dq_h_oe(dbl_if_inst.dq_h_oe),
    .dq_d_oe(dbl_if_inst.dq_d_oe), .dll_ok(dbl_if_inst.dll_ok));
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    n_beat += (wr_beat === 1'b1);
    n_drop += (wr_drop === 1'b1);
    n_oe += (dbl_if_inst.dq_h_oe === 1'b1);
    n_term += ((wr_beat === 1'b1 || wr_drop === 1'b1) && term_on !== 1'b1);
    n_term += (rd_valid === 1'b1 && term_on !== 1'b0);
  end
  // ----------------
  // Model and tasks
  // ----------------
  function automatic int nbeats(input int a12);
    nbeats = ((mode & 3) == 2 || ((mode & 3) == 1 && a12 == 0)) ? 4 : 8;
  endfunction : nbeats
  task automatic end_of_test();
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic run_cmd(input dbl_cmd_t c, input int a, input logic [63:0] wd, input bit exp_err);
    int nb;
    int n;
    int cnt;
    int cl;
    bit err;
    bit fin;
    nb = nbeats((a >> 12) & 1);
    n = 0;
    err = 0;
    fin = 1'b0;
    n_beat = 0;
    n_drop = 0;
    n_term = 0;
    n_oe = 0;
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a[15:0];
    req_wdata = wd;
    do @(posedge clk); while (req_ready !== 1'b1);
    #1 req_valid = 1'b0;
    for (cnt = 0; cnt < 900 && !err; cnt++)
    begin
      if (drop_dll && n_beat > 0)
        dll_locked = 1'b0;
      if (rd_valid === 1'b1)
      begin
        `CHK("rd_data", mem[((a & 63) + n) % 64], rd_data)
        n++;
      end
      err |= (req_err === 1'b1);
      if (done === 1'b1)
      begin
        fin = 1'b1;
        break;
      end
      @(posedge clk);
      #1;
    end
    `CHK("refused", exp_err, err)
    `CHK("finished", !exp_err, fin)
    for (cnt = 0; cnt < 40 && req_ready !== 1'b1; cnt++)
      @(posedge clk);
    repeat (8) @(posedge clk);
    #1;
    `CHK("read beats", (c == DBL_CMD_RD) ? nb : 0, n)
    `CHK("term_on", 0, n_term)
    if (c == DBL_CMD_WR && !exp_err)
    begin
      `CHK("hold cycles", 2 * DBL_CK_HALF * nb + (trained ? 0 : 2), n_oe)
      `CHK("stored", drop_dll ? 1 : nb, n_beat)
      `CHK("dropped", drop_dll ? nb - 1 : 0, n_drop)
      for (n = 0; n < (drop_dll ? 1 : nb); n++)
        mem[((a & 63) + n) % 64] = wd[8*n +: 8];
    end
    if (c == DBL_CMD_MRS)
    begin
      mode = a;
      cl = (a >> 2) & 15;
      `CHK("mode", a[15:0], mode_word)
      `CHK("rd_lat", cl + (((a >> 11) & 1) ? cl - 1 : 0) + (((a >> 10) & 1) ? 4 : 0), rd_lat)
    end
  endtask : run_cmd
  // ----------------
  // Sequence
  // ----------------
  initial
  begin
    int a;
    void'($urandom(32'h705d));
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset mode", 16'h026c, mode_word)
    `CHK("reset rd_lat", 11, rd_lat)
    run_cmd(DBL_CMD_WR, 0, 64'h0, 1'b1);
    run_cmd(DBL_CMD_NOP, 0, 64'h0, 1'b1);
    dll_locked = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 8; i++)
      run_cmd(DBL_CMD_WR, (i * 8) | ($urandom & 16'h1000), {$urandom, $urandom}, 1'b0);
    for (int i = 0; i < 12; i++)
    begin
      a = (i % 4) | ($urandom_range(15, 9) << 2) | ($urandom_range(12, 9) << 6) | ($urandom_range(1, 0) << 10);
      a = a | ($urandom_range(1, 0) << 11) | ($urandom_range(4, 0) << 13);
      run_cmd(DBL_CMD_MRS, a, 64'h0, 1'b0);
      trained = (i != 5);
      drop_dll = (i == 7);
      a = $urandom_range(63, 0) | ($urandom & 16'h1000);
      run_cmd(DBL_CMD_WR, a, {$urandom, $urandom}, 1'b0);
      drop_dll = 0;
      trained = 1'b1;
      if (i == 7)
      begin
        run_cmd(DBL_CMD_WR, a, 64'h0, 1'b1);
        dll_locked = 1'b1;
        repeat (4) @(posedge clk);
        #1;
      end
      run_cmd(DBL_CMD_RD, (a & 63) | ($urandom & 16'h1000), 64'h0, 1'b0);
    end
    end_of_test();
  end
  initial
  begin
    #1000000;
    err_total++;
    end_of_test();
  end
endmodule : dram_burst_latency_config_test
